//--- logic/sync2.v
`timescale 1ns/1ps
module sync2 #(
    parameter RESET_VAL = 1'b0
) (
    input wire ref_clk,
    input wire rst_b,
    input wire d,
    output reg q
);
    reg meta_q;

    always @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync2

//--- logic/sys_integ_defines.vh
`ifndef SYS_INTEG_DEFINES_VH
`define SYS_INTEG_DEFINES_VH

// Register addresses (word index on the plain port)
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_PCE 4'h2
`define ADDR_SECURITY 4'h3

// Control register fields
`define CTRL_STOP_DIS_TEMP 0
`define CTRL_WAIT_DIS_TEMP 1
`define CTRL_STOP_DIS_PERM 2
`define CTRL_WAIT_DIS_PERM 3
`define CTRL_SW_RESET 4
`define CTRL_RESET 16'h0000

// Peripheral clock enable reset value
`define PCE_RESET 16'hffff

// Power modes
`define MODE_RUN 2'h0
`define MODE_WAIT 2'h1
`define MODE_STOP 2'h2

// Boot modes
`define BOOT_INTERNAL 2'h0
`define BOOT_EXTERNAL 2'h1
`define BOOT_SECURE 2'h2

// Secure boot vector
`define SECURE_BOOT_ADDR 24'h020000

// Timing: power-on stretch of 2^21 cycles, then 32-cycle windows
`define POR_STRETCH_CYCLES 2097152
`define WINDOW_CYCLES 32
`define SYSTEM_CLOCK_MHZ 125

// Security byte pattern that leaves the device unsecured
`define SEC_UNLOCK_PATTERN 16'hfffe

`endif

//--- logic/system_integration_unit.v
// How it works
// - Run mode keeps core, memory and peripheral clocks enabled.
// - Wait mode gates core and memory clocks, peripherals keep running.
// - An unmasked peripheral interrupt in Wait returns the core to Run.
// - Stop exits only on CAN wake, async interrupt, watchdog, software, external or power-on reset.
// - All peripherals but the watchdog use the peripheral bus clock.
// - Control register disables Stop/Wait temporarily or until next reset.
// - Four reset sources: pin and power-on async, software and watchdog sync.
// - Power-on reset is stretched 2^21 clocks for clock settling.
// - Then three 32-clock windows: clocks, peripherals, core; then code runs.
// - Internal resets always release on a rising system clock edge.
// - Security comes from two nonvolatile flash bytes, persistent.
// - Secured: no external program space, no external boot, no core debug.
// - Boot selects internal, external or secure; secure boots at 0x02_0000.
// - Secured device ignores the external boot select pin.
// - Chip-level TAP is active after boot.
// - Core debug memory read disable is loaded from security bytes at reset.
// - Peripheral and system clocks run at half the master clock.
`timescale 1ns/1ps
`include "sys_integ_defines.vh"
module system_integration_unit #(
    parameter POR_CYCLES = `POR_STRETCH_CYCLES
) (
    input wire ref_clk,
    input wire rst_b,
    input wire por_b,
    input wire ext_reset_b,
    input wire watchdog_timer_reset,
    input wire external_boot_select_pin,
    input wire [15:0] sec_byte_pair,
    input wire stop_req,
    input wire wait_req,
    input wire periph_irq,
    input wire can_wake,
    input wire async_irq,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata,
    output reg master_div_q,
    output reg core_clk_en,
    output reg mem_clk_en,
    output reg periph_clk_en,
    output reg [15:0] periph_pce,
    output reg core_reset_b,
    output reg periph_reset_b,
    output reg clk_start,
    output reg [1:0] boot_mode,
    output reg [23:0] boot_vector,
    output reg ext_pspace_en,
    output reg core_debug_port_en,
    output reg mem_read_dis,
    output reg tap_active,
    output reg [1:0] power_mode,
    output reg stop_ack
);
    localparam ST_POR = 3'h0;
    localparam ST_CLK = 3'h1;
    localparam ST_PER = 3'h2;
    localparam ST_CORE = 3'h3;
    localparam ST_RUN = 3'h4;

    localparam WIN_LAST = `WINDOW_CYCLES - 1;

    wire por_sync;
    wire ext_sync;
    wire boot_pin_sync;
    wire can_sync;
    wire airq_sync;

    // Asynchronous sources pass two flops; assertion seen in two cycles
    sync2 #(
        .RESET_VAL(1'b0)
    ) u_por (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(~por_b),
        .q(por_sync)
    );
    sync2 #(
        .RESET_VAL(1'b0)
    ) u_ext (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(~ext_reset_b),
        .q(ext_sync)
    );
    sync2 #(
        .RESET_VAL(1'b0)
    ) u_boot (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(external_boot_select_pin),
        .q(boot_pin_sync)
    );
    sync2 #(
        .RESET_VAL(1'b0)
    ) u_can (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(can_wake),
        .q(can_sync)
    );
    sync2 #(
        .RESET_VAL(1'b0)
    ) u_airq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(async_irq),
        .q(airq_sync)
    );

    reg [15:0] ctrl_q;
    reg [15:0] pce_q;
    reg sw_reset_q;
    reg por_seen_q;
    reg [2:0] state_q;
    reg [21:0] cnt_q;
    reg secure_q;
    reg [1:0] mode_q;

    wire any_reset = por_sync | ext_sync | watchdog_timer_reset | sw_reset_q;
    wire stop_dis = ctrl_q[`CTRL_STOP_DIS_TEMP] | ctrl_q[`CTRL_STOP_DIS_PERM];
    wire wait_dis = ctrl_q[`CTRL_WAIT_DIS_TEMP] | ctrl_q[`CTRL_WAIT_DIS_PERM];
    wire sec_now = (sec_byte_pair != `SEC_UNLOCK_PATTERN);
    wire running = (state_q == ST_RUN);

    // Security and boot are sampled once, as the peripherals leave reset
    wire latch_now = (state_q == ST_PER) && (cnt_q == 22'h000000);

    // Core and memory clocks only in Run, peripherals lose theirs only in Stop
    wire core_gate_on = clk_start && (mode_q == `MODE_RUN);
    wire periph_gate_on = clk_start && (mode_q != `MODE_STOP);

    // Master clock divided by two for core and peripheral clocks
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            master_div_q <= 1'b0;
        end else begin
            master_div_q <= ~master_div_q;
        end
    end

    // Control and clock enable registers
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RESET;
            pce_q <= `PCE_RESET;
            sw_reset_q <= 1'b0;
        end else begin
            sw_reset_q <= 1'b0;
            if (any_reset) begin
                // Permanent disables last only until the next reset
                ctrl_q <= `CTRL_RESET;
                pce_q <= `PCE_RESET;
            end else if (wr_en) begin
                if (addr == `ADDR_CONTROL) begin
                    ctrl_q[`CTRL_STOP_DIS_TEMP] <= wdata[`CTRL_STOP_DIS_TEMP];
                    ctrl_q[`CTRL_WAIT_DIS_TEMP] <= wdata[`CTRL_WAIT_DIS_TEMP];
                    // Permanent bits are write-one only
                    ctrl_q[`CTRL_STOP_DIS_PERM] <= ctrl_q[`CTRL_STOP_DIS_PERM] |
                        wdata[`CTRL_STOP_DIS_PERM];
                    ctrl_q[`CTRL_WAIT_DIS_PERM] <= ctrl_q[`CTRL_WAIT_DIS_PERM] |
                        wdata[`CTRL_WAIT_DIS_PERM];
                    sw_reset_q <= wdata[`CTRL_SW_RESET];
                end
                if (addr == `ADDR_PCE) begin
                    pce_q <= wdata;
                end
            end
        end
    end

    // Reset release sequencer
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= ST_POR;
            cnt_q <= 22'h000000;
            por_seen_q <= 1'b1;
        end else if (any_reset) begin
            // Restart from the top on any new assertion
            state_q <= ST_POR;
            cnt_q <= 22'h000000;
            por_seen_q <= por_seen_q | por_sync;
        end else begin
            case (state_q)
                ST_POR: begin
                    // Only a power-on reset earns the long stretch
                    if (!por_seen_q || cnt_q == POR_CYCLES[21:0] - 22'h000001) begin
                        state_q <= ST_CLK;
                        cnt_q <= 22'h000000;
                        por_seen_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 22'h000001;
                    end
                end
                ST_CLK, ST_PER, ST_CORE: begin
                    if (cnt_q == WIN_LAST) begin
                        state_q <= state_q + 3'h1;
                        cnt_q <= 22'h000000;
                    end else begin
                        cnt_q <= cnt_q + 22'h000001;
                    end
                end
                ST_RUN: begin
                    cnt_q <= 22'h000000;
                end
                default: begin
                    state_q <= ST_POR;
                    cnt_q <= 22'h000000;
                end
            endcase
        end
    end

    // Registered reset outputs, released on the clock edge
    // so no internal reset ever lets go between two edges
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            clk_start <= 1'b0;
            periph_reset_b <= 1'b0;
            core_reset_b <= 1'b0;
        end else begin
            clk_start <= !any_reset && (state_q >= ST_CLK);
            periph_reset_b <= !any_reset && (state_q >= ST_PER);
            core_reset_b <= !any_reset && (state_q >= ST_CORE);
        end
    end

    // Security and boot mode latch during the peripheral release window
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            secure_q <= 1'b1;
            boot_mode <= `BOOT_SECURE;
            boot_vector <= `SECURE_BOOT_ADDR;
            ext_pspace_en <= 1'b0;
            core_debug_port_en <= 1'b0;
            mem_read_dis <= 1'b1;
        end else begin
            if (latch_now) begin
                secure_q <= sec_now;
                mem_read_dis <= sec_now;
                core_debug_port_en <= !sec_now;
                ext_pspace_en <= !sec_now;
                if (sec_now) begin
                    // Boot pin ignored when secured
                    boot_mode <= `BOOT_SECURE;
                    boot_vector <= `SECURE_BOOT_ADDR;
                end else if (boot_pin_sync) begin
                    boot_mode <= `BOOT_EXTERNAL;
                    boot_vector <= 24'h000000;
                end else begin
                    boot_mode <= `BOOT_INTERNAL;
                    boot_vector <= `SECURE_BOOT_ADDR;
                end
            end
        end
    end

    // The test port comes up together with the core at the end of boot
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            tap_active <= 1'b0;
        end else begin
            tap_active <= !any_reset && (state_q >= ST_CORE);
        end
    end

    // Power mode state
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_q <= `MODE_RUN;
        end else if (!running || any_reset) begin
            mode_q <= `MODE_RUN;
        end else begin
            case (mode_q)
                `MODE_RUN: begin
                    if (stop_req && !stop_dis) begin
                        mode_q <= `MODE_STOP;
                    end else if (wait_req && !wait_dis) begin
                        mode_q <= `MODE_WAIT;
                    end
                end
                `MODE_WAIT: begin
                    if (periph_irq || airq_sync) begin
                        mode_q <= `MODE_RUN;
                    end
                end
                `MODE_STOP: begin
                    // Resets are handled above; CAN wake drops the first frame
                    if (can_sync || airq_sync) begin
                        mode_q <= `MODE_RUN;
                    end
                end
                default: begin
                    mode_q <= `MODE_RUN;
                end
            endcase
        end
    end

    // Clock gates derived from mode
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            core_clk_en <= 1'b0;
            mem_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            periph_pce <= 16'h0000;
            power_mode <= `MODE_RUN;
            stop_ack <= 1'b0;
        end else begin
            core_clk_en <= core_gate_on;
            mem_clk_en <= core_gate_on;
            periph_clk_en <= periph_gate_on;
            periph_pce <= periph_gate_on ? pce_q : 16'h0000;
            power_mode <= mode_q;
            stop_ack <= (mode_q == `MODE_STOP);
        end
    end

    // Read views of the control, status and security words
    wire [15:0] control_word = {12'h000, ctrl_q[3:0]};
    wire [15:0] status_word = {9'h000, state_q, 2'h0, mode_q};
    wire [15:0] security_word = {12'h000, boot_mode, 1'b0, secure_q};

    // Register reads, data one cycle after the strobe
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (rd_en) begin
            case (addr)
                `ADDR_CONTROL: rdata <= control_word;
                `ADDR_STATUS: rdata <= status_word;
                `ADDR_PCE: rdata <= pce_q;
                `ADDR_SECURITY: rdata <= security_word;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule // system_integration_unit

//--- testbench/far_side_model.sv
`timescale 1ns/1ps
`include "sys_integ_defines.vh"
module far_side_model (
    input logic ref_clk,
    input logic core_clk_en,
    input logic core_reset_b,
    input logic go_stop,
    input logic go_wait,
    input logic secure,
    output logic stop_req,
    output logic wait_req,
    output logic [15:0] sec_byte_pair
);
    // Flash bytes are nonvolatile, no reset touches them
    assign sec_byte_pair = secure ? 16'h0000 : `SEC_UNLOCK_PATTERN;
    // Core issues instructions only while clocked; clock is off the PLL before Stop
    always @(posedge ref_clk) begin
        stop_req <= go_stop && core_clk_en && core_reset_b;
        wait_req <= go_wait && core_clk_en && core_reset_b;
    end
endmodule // far_side_model

//--- testbench/power_mode_reset_security_ctrl_tb.sv
`timescale 1ns/1ps
`include "sys_integ_defines.vh"
module power_mode_reset_security_ctrl_tb;
    logic ref_clk = 1'b0, rst_b = 1'b0, por_b = 1'b1, ext_reset_b = 1'b1;
    logic watchdog_timer_reset = 1'b0, external_boot_select_pin = 1'b1;
    logic periph_irq = 1'b0, can_wake = 1'b0, async_irq = 1'b0, secure = 1'b0;
    logic wr_en = 1'b0, rd_en = 1'b0, go_stop = 1'b0, go_wait = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic stop_req, wait_req, master_div_q, core_clk_en, mem_clk_en, periph_clk_en;
    logic core_reset_b, periph_reset_b, clk_start, ext_pspace_en, core_debug_port_en;
    logic mem_read_dis, tap_active, stop_ack;
    logic [1:0] boot_mode, power_mode;
    logic [15:0] rdata, sec_byte_pair, periph_pce;
    logic [23:0] boot_vector;
    wire [2:0] seq = {core_reset_b, periph_reset_b, clk_start};
    int failures = 0, check_count = 0, n;
    system_integration_unit #(.POR_CYCLES(64)) u_dut (.*);
    far_side_model u_core (.*);
    initial forever #4 ref_clk = ~ref_clk;
    task tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task chk(input string what, input logic [23:0] exp, got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        tick(1);
        wr_en <= 1'b0;
        tick(1);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        tick(1);
        rd_en <= 1'b0;
        chk("rdata", exp, rdata);
        tick(1);
    endtask
    // One-cycle Stop (s=1) or Wait (s=0) instruction from the core
    task cmd(input logic s);
        go_stop <= s;
        go_wait <= !s;
        tick(1);
        go_stop <= 1'b0;
        go_wait <= 1'b0;
        tick(4);
    endtask
    task wait_hi(input int b);
        while (seq[b] !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
    endtask
    task t_boot(input logic s);
        int c;
        secure <= s;
        external_boot_select_pin <= 1'b1;
        rst_b <= 1'b0;
        tick(12);
        rst_b <= 1'b1;
        n = 0;
        wait_hi(0);
        chk("stretch", 1, n >= 64);
        c = n;
        wait_hi(1);
        chk("clk window", 32, 24'(n - c));
        c = n;
        wait_hi(2);
        chk("per window", 32, 24'(n - c));
        tick(34);
        chk("clocks", 3'h7, {core_clk_en, mem_clk_en, periph_clk_en});
        chk("pce", 16'hffff, periph_pce);
        chk("boot", s ? `BOOT_SECURE : `BOOT_EXTERNAL, boot_mode);
        chk("locks", {!s, !s, s, 1'b1},
            {ext_pspace_en, core_debug_port_en, mem_read_dis, tap_active});
        if (s) chk("vector", `SECURE_BOOT_ADDR, boot_vector);
    endtask
    task t_wait;
        cmd(1'b0);
        chk("wait", `MODE_WAIT, power_mode);
        chk("gating", 3'h1, {core_clk_en, mem_clk_en, periph_clk_en});
        periph_irq <= 1'b1;
        tick(3);
        periph_irq <= 1'b0;
        chk("irq wake", `MODE_RUN, power_mode);
        tick(2);
    endtask
    task t_stop(input logic irq);
        cmd(1'b1);
        tick(8);
        chk("stop", `MODE_STOP, power_mode);
        chk("stop ack", 1'b1, stop_ack);
        chk("stop pce", 16'h0000, periph_pce);
        async_irq <= irq;
        can_wake <= !irq;
        tick(6);
        async_irq <= 1'b0;
        can_wake <= 1'b0;
        chk("stop wake", `MODE_RUN, power_mode);
        tick(2);
    endtask
    task t_disable;
        wr(`ADDR_CONTROL, 16'h0001);
        rd(`ADDR_CONTROL, 16'h0001);
        cmd(1'b1);
        chk("stop off", `MODE_RUN, power_mode);
        wr(`ADDR_CONTROL, 16'h0000);
        t_stop(1'b1);
        wr(`ADDR_CONTROL, 16'h0008);
        wr(`ADDR_CONTROL, 16'h0000);
        cmd(1'b0);
        chk("wait off", `MODE_RUN, power_mode);
        rd(4'hf, 16'h0000);
        rd(`ADDR_PCE, 16'hffff);
        wr(`ADDR_PCE, 16'h00f0);
        rd(`ADDR_PCE, 16'h00f0);
        chk("pce out", 16'h00f0, periph_pce);
        rd(`ADDR_STATUS, 16'h0040);
        wr(`ADDR_CONTROL, 16'h0010);
        tick(1);
        chk("sw reset", 3'h0, seq);
        external_boot_select_pin <= 1'b0;
        n = 0;
        wait_hi(2);
        tick(34);
        chk("boot int", `BOOT_INTERNAL, boot_mode);
        rd(`ADDR_SECURITY, 16'h0000);
        rd(`ADDR_PCE, 16'hffff);
        t_wait;
    endtask
    task t_restart;
        watchdog_timer_reset <= 1'b1;
        tick(1);
        watchdog_timer_reset <= 1'b0;
        tick(1);
        chk("wd reset", 3'h0, seq);
        n = 0;
        wait_hi(0);
        tick(10);
        ext_reset_b <= 1'b0;
        tick(5);
        chk("restart", 3'h0, seq);
        ext_reset_b <= 1'b1;
        wait_hi(2);
        chk("kept secure", `BOOT_SECURE, boot_mode);
        rd(`ADDR_SECURITY, 16'h0009);
    endtask
    initial begin
        t_boot(1'b0);
        t_wait;
        t_stop(1'b0);
        t_disable;
        t_boot(1'b1);
        t_restart;
        close_out;
    end
    initial begin
        #200000;
        failures++;
        close_out;
    end
endmodule // power_mode_reset_security_ctrl_tb

//--- testbench/sys_integ_checker.sv
`timescale 1ns/1ps
`include "sys_integ_defines.vh"
module sys_integ_checker #(
    parameter POR_CYCLES = 64
) (
    input logic ref_clk,
    input logic rst_b,
    input logic por_b,
    input logic ext_reset_b,
    input logic watchdog_timer_reset,
    input logic external_boot_select_pin,
    input logic [15:0] sec_byte_pair,
    input logic periph_irq,
    input logic can_wake,
    input logic async_irq,
    input logic master_div_q,
    input logic core_clk_en,
    input logic mem_clk_en,
    input logic periph_clk_en,
    input logic core_reset_b,
    input logic periph_reset_b,
    input logic clk_start,
    input logic [1:0] boot_mode,
    input logic [23:0] boot_vector,
    input logic ext_pspace_en,
    input logic core_debug_port_en,
    input logic mem_read_dis,
    input logic tap_active,
    input logic [1:0] power_mode
);
    // Cycles since reset release, saturating
    logic [22:0] cnt_q;
    always @(posedge ref_clk)
        if (!rst_b) cnt_q <= 23'h0;
        else if (cnt_q != 23'h7fffff) cnt_q <= cnt_q + 23'h1;
    wire sec = sec_byte_pair != `SEC_UNLOCK_PATTERN;
    wire quiet = !can_wake && !async_irq && !watchdog_timer_reset && ext_reset_b && por_b;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_run_clocks_on: assert property (power_mode == `MODE_RUN && $stable(power_mode) &&
        core_reset_b && $past(core_reset_b) |-> core_clk_en && mem_clk_en && periph_clk_en)
        else $error("run clocks off");
    a_wait_gating: assert property (power_mode == `MODE_WAIT && $stable(power_mode) |->
        !core_clk_en && !mem_clk_en && periph_clk_en) else $error("wait gating wrong");
    a_wait_wakes: assert property (power_mode == `MODE_WAIT && periph_irq |->
        ##[1:3] power_mode == `MODE_RUN) else $error("no wake from wait");
    a_stop_holds: assert property ((power_mode == `MODE_STOP && quiet)[*4] |=>
        power_mode == `MODE_STOP) else $error("stop left without cause");
    a_div_toggles: assert property ($past(rst_b) |->
        master_div_q != $past(master_div_q)) else $error("divider stuck");
    a_por_stretch: assert property ($rose(clk_start) |->
        cnt_q >= POR_CYCLES) else $error("stretch too short");
    a_periph_window: assert property ($rose(periph_reset_b) |->
        !$past(clk_start, 33) && $past(clk_start, 32)) else $error("bad clock window");
    a_core_window: assert property ($rose(core_reset_b) |->
        !$past(periph_reset_b, 33) && $past(periph_reset_b, 32)) else $error("bad window");
    a_secure_lock: assert property (core_reset_b && sec |->
        boot_mode == `BOOT_SECURE && boot_vector == `SECURE_BOOT_ADDR && !ext_pspace_en &&
        !core_debug_port_en && mem_read_dis) else $error("secure lock missing");
    a_open_boot: assert property (core_reset_b && !sec |-> tap_active && !mem_read_dis &&
        boot_mode == (external_boot_select_pin ? `BOOT_EXTERNAL : `BOOT_INTERNAL))
        else $error("open boot wrong");
    c_wait: cover property (power_mode == `MODE_WAIT);
    c_stop: cover property (power_mode == `MODE_STOP);
    c_secure: cover property (core_reset_b && sec);
endmodule // sys_integ_checker
bind system_integration_unit sys_integ_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);
